// File: verilog/fmop_core.sv
// fm operator with pitch, phase, modulation scaling and envelope generator
`timescale 1ns/10ps
module fmop_core (
  // clock and reset
  input  wire logic               mclk_i,
  input  wire logic               rst_b_i,
  // ahb-lite slave
  input  wire logic               hsel_i,
  input  wire logic [7:0]         haddr_i,
  input  wire logic [1:0]         htrans_i,
  input  wire logic               hwrite_i,
  input  wire logic [2:0]         hsize_i,
  input  wire logic [31:0]        hwdata_i,
  input  wire logic               hready_i,
  output logic      [31:0]        hrdata_o,
  output logic                    hreadyout_o,
  output logic                    hresp_o,
  // note events and modulation
  input  wire fmop_pkg::fmop_note_t note_i,
  input  wire fmop_pkg::fmop_mod_t  mod_i,
  // operator output
  output logic      [15:0]        wave_o,
  output logic      [5:0]         env_level_o,
  output logic      [15:0]        pitch_hz_o
);
  import fmop_pkg::*;
  typedef enum logic [2:0] {
    FMOP_ST_IDLE, FMOP_ST_HOLD, FMOP_ST_SEG, FMOP_ST_SUSTAIN, FMOP_ST_REL1, FMOP_ST_REL2
  } fmop_st_t;
  // registers
  logic [31:0] ctrl_q, pitch_q, hold_q, krate_q, rrel_q, klvla_q, klvlb_q;
  logic [6:0]  note_q;
  fmop_st_t    st_q;
  logic [1:0]  seg_q;
  logic [11:0] env_q;
  logic [11:0] hold_cnt_q;
  logic [9:0]  tick_cnt_q;
  logic        tick_q;
  logic [31:0] phase_q;
  logic [15:0] pitch_q2;
  logic [15:0] mod_sum_q;
  // bus pipeline
  logic        wr_pend_q;
  logic [7:0]  addr_q;
  logic        rd_pend;
  logic [31:0] rd_data;
  wire         bus_take = hsel_i & hready_i & htrans_i[1];
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend_q   <= 1'b0;
      addr_q      <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend_q <= bus_take & hwrite_i;
      if (bus_take) begin
        addr_q <= haddr_i;
      end
    end
  end
  assign rd_pend = bus_take & ~hwrite_i;
  // register writes
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q  <= FMOP_CTRL_RST;
      pitch_q <= FMOP_PITCH_RST;
      hold_q  <= FMOP_LVL_RST;
      krate_q <= FMOP_RATE_RST;
      rrel_q  <= FMOP_RATE_RST;
      klvla_q <= FMOP_LVL_RST;
      klvlb_q <= FMOP_LVL_RST;
    end else if (wr_pend_q) begin
      case (addr_q)
        FMOP_REG_CTRL:  ctrl_q  <= hwdata_i;
        FMOP_REG_PITCH: pitch_q <= hwdata_i;
        FMOP_REG_HOLD:  hold_q  <= {26'h0, hwdata_i[5:0]};
        FMOP_REG_KRATE: krate_q <= hwdata_i & 32'h3F3F_3F3F;
        FMOP_REG_RREL:  rrel_q  <= hwdata_i & 32'h3F3F_3F3F;
        FMOP_REG_KLVLA: klvla_q <= hwdata_i & 32'h3F3F_3F3F;
        FMOP_REG_KLVLB: klvlb_q <= hwdata_i & 32'h033F_3F3F;
        default: ;
      endcase
    end
  end
  // register reads, unmapped reads zero
  always_comb begin
    case (haddr_i)
      FMOP_REG_CTRL:  rd_data = ctrl_q;
      FMOP_REG_PITCH: rd_data = pitch_q;
      FMOP_REG_HOLD:  rd_data = hold_q;
      FMOP_REG_KRATE: rd_data = krate_q;
      FMOP_REG_RREL:  rd_data = rrel_q;
      FMOP_REG_KLVLA: rd_data = klvla_q;
      FMOP_REG_KLVLB: rd_data = klvlb_q;
      FMOP_REG_NOTE:  rd_data = {25'h0, note_q};
      FMOP_REG_STAT:  rd_data = {16'h0, 3'(st_q), seg_q, 5'h0, env_q[11:6]};
      FMOP_REG_PHASE: rd_data = phase_q;
      default:        rd_data = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (rd_pend) begin
      hrdata_o <= rd_data;
    end
  end
  // fields
  wire [2:0]  lvl1   = ctrl_q[FMOP_CTL_LVL1_POS +: 3];
  wire [2:0]  lvl2   = ctrl_q[FMOP_CTL_LVL2_POS +: 3];
  wire [1:0]  src1   = ctrl_q[FMOP_CTL_SRC1_POS +: 2];
  wire [1:0]  src2   = ctrl_q[FMOP_CTL_SRC2_POS +: 2];
  wire        fixed  = ctrl_q[FMOP_CTL_FIXED_POS];
  wire [3:0]  shape  = ctrl_q[FMOP_CTL_WAVE_POS +: 4];
  wire        sync   = ctrl_q[FMOP_CTL_SYNC_POS];
  wire [6:0]  iphase = ctrl_q[FMOP_CTL_IPH_POS +: 7];
  wire [4:0]  detune = ctrl_q[FMOP_CTL_DET_POS +: 5];
  wire [3:0]  krs    = ctrl_q[FMOP_CTL_KRS_POS +: 4];
  wire [1:0]  loop_pt = klvlb_q[25:24];
  // modulation scaling; feedback and operator inputs share the same level path
  function automatic logic [15:0] fmop_scale(input logic [15:0] m, input logic [2:0] l,
                                             input logic [1:0] s);
    logic signed [18:0] p;
    // widen before the product, a full-scale input times seven overflows 16 bits
    p = 19'($signed(m)) * 19'($signed({1'b0, l}));
    if (s == 2'(FMOP_SRC_NONE)) begin
      fmop_scale = 16'h0000;
    end else begin
      fmop_scale = 16'(p >>> 3);
    end
  endfunction : fmop_scale
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mod_sum_q <= 16'h0000;
    end else begin
      mod_sum_q <= 16'(fmop_scale(mod_i.first_mod_input, lvl1, src1)
                     + fmop_scale(mod_i.second_mod_input, lvl2, src2));
    end
  end
  // pitch in hz
  logic [15:0] pitch_d;
  logic [31:0] ratio_hz;
  logic [15:0] ratio_c, fixed_c, note_hz;
  logic [31:0] det_adj;
  always_comb begin
    fixed_c = (pitch_q[15:0] > FMOP_FIXED_MAX) ? FMOP_FIXED_MAX : pitch_q[15:0];
    ratio_c = (pitch_q[15:0] < FMOP_RATIO_MIN) ? FMOP_RATIO_MIN : pitch_q[15:0];
    // note pitch by octave from a3 only; semitones within octave ignored
    if (note_q >= FMOP_A3_NOTE) begin
      note_hz = 16'(FMOP_A3_HZ << ((note_q - FMOP_A3_NOTE) / 7'd12));
    end else begin
      note_hz = 16'(FMOP_A3_HZ >> ((FMOP_A3_NOTE - note_q) / 7'd12));
    end
    ratio_hz = (32'(note_hz) * 32'(ratio_c)) >> 10;
    pitch_d  = fixed ? fixed_c : ratio_hz[15:0];
    // signed throughout, so a negative detune really lowers the pitch
    det_adj  = ($signed(32'(pitch_d)) * 32'($signed(detune))) / $signed(32'(FMOP_DET_DIV));
    pitch_d  = 16'(pitch_d + det_adj[15:0]);
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pitch_q2   <= 16'h0000;
      pitch_hz_o <= 16'h0000;
    end else begin
      pitch_q2   <= pitch_d;
      pitch_hz_o <= pitch_d;
    end
  end
  // phase accumulator, 32-bit per 100 mhz, increment = hz * 2^32 / 1e8
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_q <= 32'h0000_0000;
    end else if (note_i.key_on && sync) begin
      phase_q <= {iphase, 25'h0};
    end else begin
      phase_q <= phase_q + 32'((64'(pitch_q2) * 64'd43) >> 0);
    end
  end
  fmop_wave u_wave (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .phase_i (16'(phase_q[31:16] + mod_sum_q)),
    .shape_i (shape),
    .wave_o  (wave_o)
  );
  // envelope tick divider
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_q <= 10'h000;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == FMOP_TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == FMOP_TICK_LAST) ? 10'h000 : 10'(tick_cnt_q + 10'h001);
    end
  end
  // target and rate of current segment
  logic [5:0] tgt, rate;
  logic [6:0] rate_s;
  logic signed [7:0] rate_k;
  always_comb begin
    case (st_q)
      FMOP_ST_REL1: begin tgt = klvlb_q[13:8];  rate = rrel_q[5:0];  end
      FMOP_ST_REL2: begin tgt = klvlb_q[21:16]; rate = rrel_q[13:8]; end
      FMOP_ST_SEG:  begin tgt = klvla_q[8*seg_q +: 6]; rate = krate_q[8*seg_q +: 6]; end
      default:      begin tgt = klvlb_q[5:0];   rate = 6'h00;        end
    endcase
    rate_k = $signed({2'b00, rate})
           + 8'($signed(krs)) * 8'($signed({1'b0, note_q[6:4]}));
    rate_s = (rate_k < 0) ? 7'h00 : (rate_k > 8'sd63) ? 7'h3F : 7'(rate_k);
  end
  wire [11:0] tgt_w  = {tgt, 6'h00};
  wire [11:0] step   = 12'(12'h001 << rate_s[5:3]) + 12'(rate_s[2:0]);
  wire        arrive = (env_q > tgt_w ? env_q - tgt_w : tgt_w - env_q) <= step;
  // envelope state machine
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q       <= FMOP_ST_IDLE;
      seg_q      <= 2'h0;
      env_q      <= 12'h000;
      hold_cnt_q <= 12'h000;
      note_q     <= 7'h00;
    end else if (note_i.key_on) begin
      note_q     <= note_i.note;
      st_q       <= FMOP_ST_HOLD;
      seg_q      <= 2'h0;
      env_q      <= {klvlb_q[5:0], 6'h00};
      hold_cnt_q <= 12'(hold_q[5:0] * FMOP_HOLD_SCALE);
    end else if (note_i.key_off && st_q inside {FMOP_ST_HOLD, FMOP_ST_SEG, FMOP_ST_SUSTAIN}) begin
      st_q <= FMOP_ST_REL1;
    end else if (tick_q) begin
      case (st_q)
        FMOP_ST_HOLD: begin
          if (hold_cnt_q == 12'h000) begin
            st_q <= FMOP_ST_SEG;
          end else begin
            hold_cnt_q <= 12'(hold_cnt_q - 12'h001);
          end
        end
        FMOP_ST_SEG, FMOP_ST_REL1, FMOP_ST_REL2: begin
          if (arrive) begin
            env_q <= tgt_w;
            if (st_q == FMOP_ST_REL1) begin
              st_q <= FMOP_ST_REL2;
            end else if (st_q == FMOP_ST_REL2) begin
              st_q <= FMOP_ST_IDLE;
            end else if (seg_q != 2'h3) begin
              seg_q <= 2'(seg_q + 2'h1);
            end else if (loop_pt == 2'(FMOP_LOOP_S4)) begin
              st_q <= FMOP_ST_SUSTAIN;
            end else begin
              seg_q <= loop_pt;
            end
          end else if (env_q < tgt_w) begin
            env_q <= 12'(env_q + step);
          end else begin
            env_q <= 12'(env_q - step);
          end
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      env_level_o <= 6'h00;
    end else begin
      env_level_o <= env_q[11:6];
    end
  end
  // checks
  keyoff_rel_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (note_i.key_off && !note_i.key_on && st_q == FMOP_ST_SEG) |=> st_q == FMOP_ST_REL1)
    else $error("key-off did not start release");
  sync_phase_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (note_i.key_on && sync) |=> phase_q == {$past(iphase), 25'h0})
    else $error("phase not restarted");
  keyon_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    note_i.key_on |=> st_q == FMOP_ST_HOLD && seg_q == 2'h0)
    else $error("key-on did not enter hold");
  none_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (src1 == 2'h0 && src2 == 2'h0) |=> mod_sum_q == 16'h0000 || $changed(ctrl_q))
    else $error("unassigned input modulates");
  sustain_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (st_q == FMOP_ST_SUSTAIN && !note_i.key_on && !note_i.key_off) |=> $stable(env_q))
    else $error("sustain level moved");
  rel_chain_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (st_q == FMOP_ST_REL1 && tick_q && arrive && !note_i.key_on) |=> st_q == FMOP_ST_REL2)
    else $error("release two not entered");
  loop_back_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (st_q == FMOP_ST_SEG && seg_q == 2'h3 && tick_q && arrive && loop_pt != 2'h3
     && !note_i.key_on && !note_i.key_off) |=> seg_q == $past(loop_pt))
    else $error("loop point not taken");
  fixed_pitch_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (fixed && detune == 5'h00 && $stable(pitch_q)) |=> pitch_hz_o <= FMOP_FIXED_MAX)
    else $error("fixed pitch out of range");
  hold_go_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    st_q == FMOP_ST_HOLD ##1 st_q == FMOP_ST_SEG);
  loop_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    st_q == FMOP_ST_SEG && seg_q == 2'h3 ##1 seg_q != 2'h3);
  rel_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    st_q == FMOP_ST_REL2 ##1 st_q == FMOP_ST_IDLE);
endmodule : fmop_core

// File: verilog/fmop_pkg.sv
// package: constants, register map and carrier types for the fm operator core
package fmop_pkg;
  // register byte offsets
  localparam logic [7:0] FMOP_REG_CTRL   = 8'h00;
  localparam logic [7:0] FMOP_REG_PITCH  = 8'h04;
  localparam logic [7:0] FMOP_REG_HOLD   = 8'h08;
  localparam logic [7:0] FMOP_REG_KRATE  = 8'h0C;
  localparam logic [7:0] FMOP_REG_RREL   = 8'h10;
  localparam logic [7:0] FMOP_REG_KLVLA  = 8'h14;
  localparam logic [7:0] FMOP_REG_KLVLB  = 8'h18;
  localparam logic [7:0] FMOP_REG_NOTE   = 8'h1C;
  localparam logic [7:0] FMOP_REG_STAT   = 8'h20;
  localparam logic [7:0] FMOP_REG_PHASE  = 8'h24;
  // field positions in ctrl
  localparam int FMOP_CTL_LVL1_POS  = 0;
  localparam int FMOP_CTL_LVL2_POS  = 3;
  localparam int FMOP_CTL_SRC1_POS  = 6;
  localparam int FMOP_CTL_SRC2_POS  = 8;
  localparam int FMOP_CTL_FIXED_POS = 10;
  localparam int FMOP_CTL_WAVE_POS  = 11;
  localparam int FMOP_CTL_SYNC_POS  = 15;
  localparam int FMOP_CTL_IPH_POS   = 16;
  localparam int FMOP_CTL_DET_POS   = 23;
  localparam int FMOP_CTL_KRS_POS   = 28;
  // reset values
  localparam logic [31:0] FMOP_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] FMOP_PITCH_RST = 32'h0000_0400;
  localparam logic [31:0] FMOP_RATE_RST  = 32'h3F3F_3F3F;
  localparam logic [31:0] FMOP_LVL_RST   = 32'h0000_0000;
  // pitch: ratio in 1/1024 units, 1024 = 1.0; fixed in hz
  localparam logic [15:0] FMOP_RATIO_MIN = 16'h0200;
  localparam logic [15:0] FMOP_RATIO_MAX = 16'hF6C2;
  localparam logic [15:0] FMOP_FIXED_MAX = 16'h2622;
  localparam logic [15:0] FMOP_A3_HZ     = 16'h01B8;
  localparam logic [6:0]  FMOP_A3_NOTE   = 7'h45;
  // detune step 1.171875 cents = 1/1024 octave, rounds to ratio x 1/1477
  localparam logic [15:0] FMOP_DET_DIV   = 16'h05C5;
  // envelope timing: divider for envelope ticks and hold scale
  localparam int FMOP_CLK_HZ        = 100_000_000;
  localparam int FMOP_TICK_US       = 10;
  localparam int FMOP_TICK_CYC      = FMOP_CLK_HZ / 1_000_000 * FMOP_TICK_US;
  localparam logic [9:0] FMOP_TICK_LAST = 10'(FMOP_TICK_CYC - 1);
  localparam logic [11:0] FMOP_HOLD_SCALE = 12'h040;
  // modulation sources
  typedef enum logic [1:0] {FMOP_SRC_NONE, FMOP_SRC_OPER, FMOP_SRC_FBK, FMOP_SRC_EXT} fmop_src_t;
  // segment loop point
  typedef enum logic [1:0] {FMOP_LOOP_S1, FMOP_LOOP_S2, FMOP_LOOP_S3, FMOP_LOOP_S4} fmop_loop_t;
  // modulation input carrier
  typedef struct packed {
    logic [15:0] first_mod_input;
    logic [15:0] second_mod_input;
  } fmop_mod_t;
  // note event carrier
  typedef struct packed {
    logic       key_on;
    logic       key_off;
    logic [6:0] note;
  } fmop_note_t;
endpackage : fmop_pkg

// File: verilog/fmop_wave.sv
// waveform shaper: sine and fifteen derived shapes from a phase
`timescale 1ns/10ps
module fmop_wave (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // phase and shape
  input  wire logic [15:0] phase_i,
  input  wire logic [3:0]  shape_i,
  // sample out
  output logic      [15:0] wave_o
);
  import fmop_pkg::*;
  logic [15:0] sine_d;
  logic [15:0] shaped_d;
  logic [13:0] ph;
  logic [15:0] tri_w;
  logic [15:0] mag;
  always_comb begin
    ph    = phase_i[15] ? ~phase_i[13:0] : phase_i[13:0];
    ph    = phase_i[14] ? ~ph : ph;
    tri_w = {2'h0, ph};
    // parabolic sine: cheap, a few percent harmonic error traded for no rom
    mag   = 16'((32'(tri_w) * 32'(16'h8000 - tri_w)) >> 13);
    sine_d = phase_i[15] ? 16'(-mag) : mag;
  end
  // harmonically richer shapes derived from the sine
  always_comb begin
    case (shape_i)
      4'h0:    shaped_d = sine_d;
      4'h1:    shaped_d = phase_i[15] ? 16'h0000 : sine_d;
      4'h2:    shaped_d = phase_i[15] ? 16'(-sine_d) : sine_d;
      4'h3:    shaped_d = phase_i[14] ? 16'h0000 : sine_d;
      default: shaped_d = 16'(sine_d ^ {16{phase_i[16'(shape_i) % 16]}});
    endcase
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wave_o <= 16'h0000;
    end else begin
      wave_o <= shaped_d;
    end
  end
endmodule : fmop_wave

// File: testbench/fmop_note_src_model.sv
// note event source and modulating operator model facing the core
`timescale 1ns/10ps
module fmop_note_src_model (
  // clock
  input  wire logic           mclk_i,
  // events and modulation to the core
  output fmop_pkg::fmop_note_t note_o,
  output fmop_pkg::fmop_mod_t  mod_o
);
  import fmop_pkg::*;
  initial begin
    note_o = '0;
    mod_o  = '0;
  end
  // one-cycle pulse, so a held key never retriggers the envelope
  task automatic key(input logic on, input logic [6:0] n);
    @(posedge mclk_i);
    note_o <= '{key_on: on, key_off: !on, note: n};
    @(posedge mclk_i);
    note_o <= '{key_on: 1'b0, key_off: 1'b0, note: n};
  endtask : key
  task automatic set_mod(input logic [15:0] a, input logic [15:0] b);
    @(posedge mclk_i);
    mod_o <= '{first_mod_input: a, second_mod_input: b};
  endtask : set_mod
endmodule : fmop_note_src_model

// File: testbench/tb_fm_operator_envelope_core.sv
// self-checking bench for the fm operator core over ahb-lite
`timescale 1ns/10ps
module tb_fm_operator_envelope_core;
  import fmop_pkg::*;
  logic        mclk, rst_b, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] wave, pitch, base, w;
  logic [5:0]  lvl;
  fmop_note_t  note;
  fmop_mod_t   modv;
  int          bad_count, cmp_count;
  logic [5:0]  nxt [3] = '{6'd14, 6'd11, 6'd13};

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  fmop_core u_fmop_core (
    .mclk_i(mclk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .note_i(note),
    .mod_i(modv), .wave_o(wave), .env_level_o(lvl), .pitch_hz_o(pitch)
  );
  fmop_note_src_model u_fmop_note_src_model (.mclk_i(mclk), .note_o(note), .mod_o(modv));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // address phase held until hready, then data phase until hready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= wr; hsize <= 3'b010;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'b00; hsel <= 1'b0; hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask : ahb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdchk
  function automatic logic [31:0] ctl(input logic [1:0] src, input logic [2:0] l1,
      input logic fx, input logic [3:0] wv, input logic sy, input logic [4:0] dt);
    ctl = (32'(l1) << FMOP_CTL_LVL1_POS) | (32'(src) << FMOP_CTL_SRC1_POS)
        | (32'(fx) << FMOP_CTL_FIXED_POS) | (32'(wv) << FMOP_CTL_WAVE_POS)
        | (32'(sy) << FMOP_CTL_SYNC_POS) | (32'(dt) << FMOP_CTL_DET_POS);
  endfunction : ctl
  task automatic pget(input logic [6:0] n, output logic [15:0] p);
    u_fmop_note_src_model.key(1'b1, n);
    repeat (10) @(posedge mclk);
    p = pitch;
    u_fmop_note_src_model.key(1'b0, n);
  endtask : pget
  // fixed delay after a synced key-on so both runs sample the same phase
  task automatic samp(output logic [15:0] s);
    u_fmop_note_src_model.key(1'b1, FMOP_A3_NOTE);
    repeat (2000) @(posedge mclk);
    // settled value, away from the edge that launches it
    @(negedge mclk);
    s = wave;
    u_fmop_note_src_model.key(1'b0, FMOP_A3_NOTE);
    repeat (20) @(posedge mclk);
  endtask : samp
  task automatic wlev(input logic [5:0] v);
    int n;
    n = 0;
    while (lvl !== v && n < 40000) begin
      @(posedge mclk);
      n++;
    end
    check(32'(lvl), 32'(v));
  endtask : wlev
  task automatic stay(input logic [5:0] v, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(posedge mclk);
      if (lvl !== v) ok = 1'b0;
    end
    check(32'(ok), 32'h0000_0001);
  endtask : stay
  // small level steps keep the envelope walk short at any rate law
  task automatic env(input logic [5:0] hold, input logic [1:0] lp);
    ahb(1'b1, FMOP_REG_HOLD, 32'(hold));
    ahb(1'b1, FMOP_REG_KRATE, 32'h3F3F_3F3F);
    ahb(1'b1, FMOP_REG_RREL, 32'h0000_3F3F);
    ahb(1'b1, FMOP_REG_KLVLA, 32'h0C0D_0B0E);
    ahb(1'b1, FMOP_REG_KLVLB, (32'(lp) << 24) | 32'h0006_080A);
  endtask : env
  task report_and_stop;
    $display("counts: compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    report_and_stop;
  end

  initial begin
    rst_b = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 8'h00; htrans = 2'b00;
    hsize = 3'b010; hwdata = 32'h0000_0000; bad_count = 0; cmp_count = 0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    rdchk(FMOP_REG_CTRL, FMOP_CTRL_RST);
    rdchk(FMOP_REG_PITCH, FMOP_PITCH_RST);
    rdchk(FMOP_REG_KRATE, FMOP_RATE_RST);
    rdchk(FMOP_REG_KLVLA, FMOP_LVL_RST);
    ahb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rdchk(8'h3C, 32'h0000_0000);
    $display("test registers done");
    ahb(1'b1, FMOP_REG_CTRL, ctl(FMOP_SRC_NONE, 3'd0, 1'b0, 4'd0, 1'b0, 5'd0));
    pget(FMOP_A3_NOTE, w);
    check(32'(w), 32'(FMOP_A3_HZ));
    pget(FMOP_A3_NOTE + 7'd12, w);
    check(32'(w), 32'(FMOP_A3_HZ) * 2);
    ahb(1'b1, FMOP_REG_PITCH, 32'(FMOP_RATIO_MIN));
    pget(FMOP_A3_NOTE, w);
    check(32'(w), 32'(FMOP_A3_HZ) / 2);
    ahb(1'b1, FMOP_REG_PITCH, 32'h0000_0400);
    ahb(1'b1, FMOP_REG_CTRL, ctl(FMOP_SRC_NONE, 3'd0, 1'b0, 4'd0, 1'b0, 5'd15));
    pget(FMOP_A3_NOTE, w);
    check(32'(w > FMOP_A3_HZ), 32'h0000_0001);
    ahb(1'b1, FMOP_REG_CTRL, ctl(FMOP_SRC_NONE, 3'd0, 1'b0, 4'd0, 1'b0, 5'h11));
    pget(FMOP_A3_NOTE, w);
    check(32'(w < FMOP_A3_HZ), 32'h0000_0001);
    ahb(1'b1, FMOP_REG_CTRL, ctl(FMOP_SRC_NONE, 3'd0, 1'b1, 4'd0, 1'b0, 5'd0));
    ahb(1'b1, FMOP_REG_PITCH, 32'h0000_03E8);
    pget(7'h30, w);
    check(32'(w), 32'h0000_03E8);
    pget(7'h50, w);
    check(32'(w), 32'h0000_03E8);
    ahb(1'b1, FMOP_REG_PITCH, 32'h0000_FFFF);
    pget(FMOP_A3_NOTE, w);
    check(32'(w), 32'(FMOP_FIXED_MAX));
    $display("test pitch done");
    for (int lp = 0; lp < 3; lp++) begin
      env(6'd0, 2'(lp));
      u_fmop_note_src_model.key(1'b1, FMOP_A3_NOTE);
      wlev(6'd14);
      wlev(6'd11);
      wlev(6'd13);
      wlev(6'd12);
      wlev(nxt[lp]);
      u_fmop_note_src_model.key(1'b0, FMOP_A3_NOTE);
      wlev(6'd8);
      wlev(6'd6);
    end
    env(6'd0, 2'd3);
    u_fmop_note_src_model.key(1'b1, FMOP_A3_NOTE);
    wlev(6'd13);
    wlev(6'd12);
    stay(6'd12, 5000);
    u_fmop_note_src_model.key(1'b0, FMOP_A3_NOTE);
    wlev(6'd6);
    env(6'd1, 2'd3);
    u_fmop_note_src_model.key(1'b1, FMOP_A3_NOTE);
    repeat (5) @(posedge mclk);
    stay(6'd10, 3000);
    u_fmop_note_src_model.key(1'b0, FMOP_A3_NOTE);
    wlev(6'd8);
    // rate zero barely moves; only key-rate scaling on a top note can
    ahb(1'b1, FMOP_REG_HOLD, 32'h0000_0000);
    ahb(1'b1, FMOP_REG_KRATE, 32'h0000_0000);
    ahb(1'b1, FMOP_REG_CTRL, ctl(FMOP_SRC_NONE, 3'd0, 1'b1, 4'd0, 1'b0, 5'd0)
        | (32'h0000_0007 << FMOP_CTL_KRS_POS));
    u_fmop_note_src_model.key(1'b1, 7'h7F);
    repeat (3000) @(posedge mclk);
    check(32'(lvl != 6'd10), 32'h0000_0001);
    u_fmop_note_src_model.key(1'b0, 7'h7F);
    $display("test envelope done");
    ahb(1'b1, FMOP_REG_HOLD, 32'h0000_0000);
    ahb(1'b1, FMOP_REG_KLVLA, 32'h3F3F_3F3F);
    ahb(1'b1, FMOP_REG_KLVLB, 32'h0300_003F);
    ahb(1'b1, FMOP_REG_CTRL, ctl(FMOP_SRC_NONE, 3'd7, 1'b1, 4'd0, 1'b1, 5'd0));
    samp(base);
    u_fmop_note_src_model.set_mod(16'h7FFF, 16'h7FFF);
    samp(w);
    check(32'(w), 32'(base));
    ahb(1'b1, FMOP_REG_CTRL, ctl(FMOP_SRC_OPER, 3'd0, 1'b1, 4'd0, 1'b1, 5'd0));
    samp(w);
    check(32'(w), 32'(base));
    ahb(1'b1, FMOP_REG_CTRL, ctl(FMOP_SRC_OPER, 3'd7, 1'b1, 4'd0, 1'b1, 5'd0));
    samp(w);
    check(32'(w !== base), 32'h0000_0001);
    ahb(1'b1, FMOP_REG_CTRL, ctl(FMOP_SRC_FBK, 3'd7, 1'b1, 4'd0, 1'b1, 5'd0));
    samp(w);
    check(32'(w !== base), 32'h0000_0001);
    ahb(1'b1, FMOP_REG_CTRL, ctl(FMOP_SRC_NONE, 3'd7, 1'b1, 4'd13, 1'b1, 5'd0));
    samp(w);
    check(32'(w !== base), 32'h0000_0001);
    ahb(1'b1, FMOP_REG_CTRL, ctl(FMOP_SRC_NONE, 3'd7, 1'b1, 4'd0, 1'b1, 5'd0)
        | (32'd64 << FMOP_CTL_IPH_POS));
    samp(w);
    check(32'(w !== base), 32'h0000_0001);
    $display("test modulation done");
    report_and_stop;
  end
endmodule : tb_fm_operator_envelope_core
